// ---- rtl/dual_timer_regs.vh ----
// constants for the dual timer/counter pair block
// assumes a classic wishbone slave with 32-bit data, word indices below
`ifndef DUAL_TIMER_REGS_VH
`define DUAL_TIMER_REGS_VH
// per-pair register word index, pair 1 adds PAIR_STRIDE
`define IDX_LOWER_MODE   4'h0
`define IDX_UPPER_MODE   4'h1
`define IDX_LOWER_DATA   4'h2
`define IDX_UPPER_DATA   4'h3
`define IDX_EDGE_SEL     4'h4
`define IDX_FLAGS        4'h5
`define IDX_PORT_FUNC    4'h6
`define PAIR_STRIDE      4'h8
// lower mode register fields
`define LM_CAP           3
`define LM_CK_HI         2
`define LM_CK_LO         0
`define LM_CK_EVENT      3'h7
// upper mode register fields
`define UM_WIDE          5
`define UM_PULSE_WIDTH_ENABLE          4
`define UM_CAP           3
`define UM_CK_HI         1
`define UM_CK_LO         0
`define UM_CK_WIDE       2'h3
// flags register bits (write 1 to clear)
`define FL_LOWER_MATCH   0
`define FL_UPPER_MATCH   1
`define FL_LOWER_EDGE    2
`define FL_UPPER_EDGE    3
// edge select codes
`define EDGE_FALL        2'h1
`define EDGE_RISE        2'h2
`define EDGE_BOTH        2'h3
// port function bit routing compare to pin
`define PF_ROUTE         0
`define MODE_RESET       8'h00
`endif

// ---- rtl/timer_prescaler.v ----
// free-running prescaler giving one-cycle ticks for each divide ratio
// assumes mclk is the oscillator reference; runs from reset
`include "dual_timer_regs.vh"
module timer_prescaler #(
  parameter WIDTH = 11
) (
  input  wire             mclk,     // system clock
  input  wire             rst,      // sync reset
  output wire [WIDTH-1:0] tickVec   // tickVec[n] pulses every 2^(n+1) clocks
);
  reg  [WIDTH-1:0] div_ff;
  reg  [WIDTH-1:0] prev_ff;
  wire [WIDTH-1:0] nxt_div;

  assign nxt_div = div_ff + {{(WIDTH-1){1'b0}}, 1'b1};

  always @(posedge mclk) begin
    if (rst) begin
      div_ff  <= {WIDTH{1'b0}};
      prev_ff <= {WIDTH{1'b0}};
    end else begin
      div_ff  <= nxt_div;
      prev_ff <= div_ff;
    end
  end

  // falling edge of each divider bit is a single tick per period
  assign tickVec = prev_ff & ~div_ff;
endmodule

// ---- rtl/dual_timer_counter.v ----
// two identical timer pairs, each 8+8 bits, chainable to 16 bits, wishbone slave
// assumes inputs synchronous to mclk; edge detection on external pins is done here
`include "dual_timer_regs.vh"
module dual_timer_counter #(
  parameter PAIRS = 2
) (
  input  wire             mclk,        // system clock, 40 MHz
  input  wire             rst,         // sync reset, active high
  input  wire [31:0]      wb_adr_i,    // byte address
  input  wire [31:0]      wb_dat_i,    // write data
  output reg  [31:0]      wb_dat_o,    // read data
  input  wire [3:0]       wb_sel_i,    // byte lanes
  input  wire             wb_we_i,     // write enable
  input  wire             wb_cyc_i,    // cycle
  input  wire             wb_stb_i,    // strobe
  output reg              wb_ack_o,    // acknowledge
  input  wire [PAIRS-1:0] eventInput,  // event input pins, one per pair
  input  wire [PAIRS-1:0] edgeLower,   // external edge input for lower capture
  input  wire [PAIRS-1:0] edgeUpper,   // external edge input for upper capture
  output wire [PAIRS-1:0] comparePin,  // compare toggle pin per pair
  output wire [PAIRS-1:0] comparePinOe,// compare pin drive enable
  output wire [PAIRS-1:0] matchIrq     // level: any flag set in the pair
);
  wire [10:0] tickVec;

  timer_prescaler #(.WIDTH(11)) u_pre (
    .mclk    (mclk),
    .rst     (rst),
    .tickVec (tickVec)
  );

  // lower select: 2,4,8,32,128,512,2048 -> tick bits 0,1,2,4,6,8,10
  function lowerTick;
    input [2:0]  sel;
    input [10:0] t;
    begin
      case (sel)
        3'h0:    lowerTick = t[0];
        3'h1:    lowerTick = t[1];
        3'h2:    lowerTick = t[2];
        3'h3:    lowerTick = t[4];
        3'h4:    lowerTick = t[6];
        3'h5:    lowerTick = t[8];
        3'h6:    lowerTick = t[10];
        default: lowerTick = 1'b0;
      endcase
    end
  endfunction

  // upper select: 1, 2, 8; code 11 is reserved for the chained mode
  function upperTick;
    input [1:0]  sel;
    input [10:0] t;
    begin
      case (sel)
        2'h0:    upperTick = 1'b1;
        2'h1:    upperTick = t[0];
        2'h2:    upperTick = t[2];
        default: upperTick = 1'b0;
      endcase
    end
  endfunction

  function edgeHit;
    input [1:0] mode;
    input       prev;
    input       cur;
    begin
      case (mode)
        `EDGE_FALL: edgeHit = prev & ~cur;
        `EDGE_RISE: edgeHit = ~prev & cur;
        `EDGE_BOTH: edgeHit = prev ^ cur;
        default:    edgeHit = 1'b0;
      endcase
    end
  endfunction

  wire [3:0] wordIdx  = wb_adr_i[5:2];
  wire [3:0] localIdx = {1'b0, wordIdx[2:0]};
  wire       pairSel  = wordIdx[3];
  wire       busReq   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire       busWr    = busReq & wb_we_i & wb_sel_i[0];
  wire       inRange  = (wb_adr_i[31:6] == 26'h0000000) && (wordIdx[2:0] <= `IDX_PORT_FUNC);

  reg [7:0] lowerMode_ff  [0:PAIRS-1];
  reg [7:0] upperMode_ff  [0:PAIRS-1];
  reg [7:0] lowerCount_ff [0:PAIRS-1];
  reg [7:0] upperCount_ff [0:PAIRS-1];
  reg [7:0] lowerData_ff  [0:PAIRS-1];
  reg [7:0] upperData_ff  [0:PAIRS-1];
  reg [7:0] lowerCap_ff   [0:PAIRS-1];
  reg [7:0] upperCap_ff   [0:PAIRS-1];
  reg [3:0] edgeSel_ff    [0:PAIRS-1];
  reg [3:0] flags_ff      [0:PAIRS-1];
  reg       route_ff      [0:PAIRS-1];
  reg       cmp_ff        [0:PAIRS-1];
  reg       evPrev_ff     [0:PAIRS-1];
  reg       loPrev_ff     [0:PAIRS-1];
  reg       upPrev_ff     [0:PAIRS-1];

  genvar g;
  generate
    for (g = 0; g < PAIRS; g = g + 1) begin : pair
      wire [7:0] lm     = lowerMode_ff[g];
      wire [7:0] um     = upperMode_ff[g];
      wire       wide   = um[`UM_WIDE] & (um[`UM_CK_HI:`UM_CK_LO] == `UM_CK_WIDE) & ~um[`UM_PULSE_WIDTH_ENABLE];
      wire       loCap  = lm[`LM_CAP];
      wire       upCap  = um[`UM_CAP] & ~wide & ~um[`UM_PULSE_WIDTH_ENABLE];
      wire       evRise = ~evPrev_ff[g] & eventInput[g];
      // select 111 counts event pin
      wire       loTick = (lm[`LM_CK_HI:`LM_CK_LO] == `LM_CK_EVENT) ? evRise :
                          lowerTick(lm[`LM_CK_HI:`LM_CK_LO], tickVec);
      wire       upTick = upperTick(um[`UM_CK_HI:`UM_CK_LO], tickVec) & ~um[`UM_PULSE_WIDTH_ENABLE];
      wire       loEdge = edgeHit(edgeSel_ff[g][1:0], loPrev_ff[g], edgeLower[g]);
      wire       upEdge = edgeHit(edgeSel_ff[g][3:2], upPrev_ff[g], edgeUpper[g]);
      wire [15:0] cnt16 = {upperCount_ff[g], lowerCount_ff[g]};
      wire [15:0] dat16 = {upperData_ff[g], lowerData_ff[g]};
      wire       loMatch = wide ? (loTick & (cnt16 == dat16))
                                : (loTick & (lowerCount_ff[g] == lowerData_ff[g]));
      wire       upMatch = ~wide & upTick & (upperCount_ff[g] == upperData_ff[g]);
      wire       pairWr = busWr & (pairSel == ((g % 2) == 1));
      wire [15:0] nxt_cnt16 = cnt16 + 16'h0001;
      wire [3:0] clrMask = (pairWr && localIdx == `IDX_FLAGS) ? wb_dat_i[3:0] : 4'h0;
      wire [3:0] setMask = {upCap & upEdge, (loCap | wide & loCap) & loEdge, upMatch, loMatch};

      always @(posedge mclk) begin
        if (rst) begin
          lowerMode_ff[g]  <= `MODE_RESET;
          upperMode_ff[g]  <= `MODE_RESET;
          lowerCount_ff[g] <= 8'h00;
          upperCount_ff[g] <= 8'h00;
          lowerData_ff[g]  <= 8'hFF;
          upperData_ff[g]  <= 8'hFF;
          lowerCap_ff[g]   <= 8'h00;
          upperCap_ff[g]   <= 8'h00;
          edgeSel_ff[g]    <= 4'h0;
          flags_ff[g]      <= 4'h0;
          route_ff[g]      <= 1'b0;
          cmp_ff[g]        <= 1'b0;
          evPrev_ff[g]     <= 1'b0;
          loPrev_ff[g]     <= 1'b0;
          upPrev_ff[g]     <= 1'b0;
        end else begin
          evPrev_ff[g] <= eventInput[g];
          loPrev_ff[g] <= edgeLower[g];
          upPrev_ff[g] <= edgeUpper[g];
          // set wins over a simultaneous software clear
          flags_ff[g]  <= (flags_ff[g] & ~clrMask) | setMask;
          if (pairWr) begin
            case (localIdx)
              `IDX_LOWER_MODE: lowerMode_ff[g] <= wb_dat_i[7:0];
              `IDX_UPPER_MODE: upperMode_ff[g] <= wb_dat_i[7:0];
              `IDX_LOWER_DATA: lowerData_ff[g] <= wb_dat_i[7:0];
              `IDX_UPPER_DATA: upperData_ff[g] <= wb_dat_i[7:0];
              `IDX_EDGE_SEL:   edgeSel_ff[g]   <= wb_dat_i[3:0];
              `IDX_PORT_FUNC:  route_ff[g]     <= wb_dat_i[`PF_ROUTE];
              default:         route_ff[g]     <= route_ff[g];
            endcase
          end
          // compare pin toggles on each match of the driving timer
          if (wide ? loMatch : upMatch)
            cmp_ff[g] <= ~cmp_ff[g];
          if (wide) begin
            if (loCap && loEdge) begin
              lowerCap_ff[g]   <= lowerCount_ff[g];
              upperCap_ff[g]   <= upperCount_ff[g];
              lowerCount_ff[g] <= 8'h00;
              upperCount_ff[g] <= 8'h00;
            end else if (loMatch) begin
              lowerCount_ff[g] <= 8'h00;
              upperCount_ff[g] <= 8'h00;
            end else if (loTick) begin
              lowerCount_ff[g] <= nxt_cnt16[7:0];
              upperCount_ff[g] <= nxt_cnt16[15:8];
            end
          end else begin
            if (loCap && loEdge) begin
              lowerCap_ff[g]   <= lowerCount_ff[g];
              lowerCount_ff[g] <= 8'h00;
            end else if (loMatch)
              lowerCount_ff[g] <= 8'h00;
            else if (loTick)
              lowerCount_ff[g] <= lowerCount_ff[g] + 8'h01;
            if (upCap && upEdge) begin
              upperCap_ff[g]   <= upperCount_ff[g];
              upperCount_ff[g] <= 8'h00;
            end else if (upMatch)
              upperCount_ff[g] <= 8'h00;
            else if (upTick)
              upperCount_ff[g] <= upperCount_ff[g] + 8'h01;
          end
        end
      end

      // pin driven only when routed and pulse-width output is off
      assign comparePin[g]   = cmp_ff[g];
      assign comparePinOe[g] = route_ff[g] & ~um[`UM_PULSE_WIDTH_ENABLE];
      assign matchIrq[g]     = |flags_ff[g];
    end
  endgenerate

  // one-wait-state slave: ack one cycle after the request is seen
  reg [31:0] nxt_rd;
  always @* begin
    nxt_rd = 32'h00000000;
    case (localIdx)
      `IDX_LOWER_MODE: nxt_rd[7:0] = lowerMode_ff[pairSel];
      `IDX_UPPER_MODE: nxt_rd[7:0] = upperMode_ff[pairSel];
      // capture mode reads capture register, data register never readable
      `IDX_LOWER_DATA: nxt_rd[7:0] = lowerMode_ff[pairSel][`LM_CAP] ? lowerCap_ff[pairSel]
                                                                     : lowerCount_ff[pairSel];
      `IDX_UPPER_DATA: nxt_rd[7:0] = (upperMode_ff[pairSel][`UM_CAP] | (upperMode_ff[pairSel][`UM_WIDE]
                                      & lowerMode_ff[pairSel][`LM_CAP])) ? upperCap_ff[pairSel]
                                                                          : upperCount_ff[pairSel];
      `IDX_EDGE_SEL:   nxt_rd[3:0] = edgeSel_ff[pairSel];
      `IDX_FLAGS:      nxt_rd[3:0] = flags_ff[pairSel];
      `IDX_PORT_FUNC:  nxt_rd[0]   = route_ff[pairSel];
      default:         nxt_rd      = 32'h00000000;
    endcase
    if (!inRange)
      nxt_rd = 32'h00000000;
  end

  always @(posedge mclk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= busReq;
      wb_dat_o <= nxt_rd;
    end
  end
endmodule

// ---- verification/dual_timer_counter_chk.sv ----
// port checker for the dual timer pair block
// assumes bind into dual_timer_counter; one clock, sync reset high
module dual_timer_counter_chk #(
  parameter PAIRS = 2
) (
  input wire             mclk,         // clock
  input wire             rst,          // reset
  input wire [31:0]      wb_adr_i,     // address
  input wire             wb_we_i,      // write
  input wire             wb_cyc_i,     // cycle
  input wire             wb_stb_i,     // strobe
  input wire [31:0]      wb_dat_o,     // read data
  input wire             wb_ack_o,     // ack
  input wire [PAIRS-1:0] comparePin,   // compare pins
  input wire [PAIRS-1:0] comparePinOe, // pin enables
  input wire [PAIRS-1:0] matchIrq      // flag summary
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("request not answered next cycle");
  property p_ack_cause; $rose(wb_ack_o) |-> $past(wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_unmapped;
    wb_ack_o && !wb_we_i && (wb_adr_i[31:6] != 0 || wb_adr_i[4:2] == 3'h7) |-> wb_dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rst_quiet;
    disable iff (1'b0) rst |=> comparePin == 0 && comparePinOe == 0 && matchIrq == 0 && !wb_ack_o;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
  property p_oe_write; $changed(comparePinOe) |-> wb_ack_o && wb_we_i; endproperty
  a_oe_write: assert property (p_oe_write) else $error("pin enable moved without write");
  property p_irq_hold; (matchIrq & $past(matchIrq)) != $past(matchIrq) |-> wb_ack_o && wb_we_i; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("flag dropped without write");
  property p_pin_flag;
    comparePin != $past(comparePin) |-> (matchIrq & (comparePin ^ $past(comparePin))) == (comparePin ^ $past(comparePin));
  endproperty
  a_pin_flag: assert property (p_pin_flag) else $error("pin toggled without match");
endmodule
bind dual_timer_counter dual_timer_counter_chk #(.PAIRS(PAIRS)) chk_u (
  .mclk(mclk), .rst(rst), .wb_adr_i(wb_adr_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .comparePin(comparePin),
  .comparePinOe(comparePinOe), .matchIrq(matchIrq));

// ---- verification/dual_timer_pins.sv ----
// far-side model: event and external edge pins of both pairs
// assumes the bench calls its tasks; pins move just after rising edges
module dual_timer_pins (
  input  wire        mclk,       // clock
  output logic [1:0] eventInput, // event pins
  output logic [1:0] edgeLower,  // lower capture pins
  output logic [1:0] edgeUpper   // upper capture pins
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    eventInput = 2'h0;
    edgeLower = 2'h0;
    edgeUpper = 2'h0;
  end
  // two cycles high, two low so every rising edge is seen apart
  task pulse(input int p, input int n);
    repeat (n) begin
      @(posedge mclk);
      eventInput[p] <= 1'h1;
      repeat (2) @(posedge mclk);
      eventInput[p] <= 1'h0;
      @(posedge mclk);
    end
  endtask
  task setEdge(input int p, input logic v);
    @(posedge mclk);
    edgeLower[p] <= v;
    repeat (3) @(posedge mclk);
  endtask
  task setUpper(input int p, input logic v);
    @(posedge mclk);
    edgeUpper[p] <= v;
    repeat (3) @(posedge mclk);
  endtask
endmodule

// ---- verification/test_dual_timer_counter.sv ----
// self-checking bench for dual_timer_counter over classic wishbone
// assumes dual_timer_pins drives the pins; single 40 MHz clock
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin numErrors++; \
  $display("wrong value at %0t: got %0h want %0h", $time, a, b); end end
module test_dual_timer_counter;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'h0;
  logic        rst = 1'h1;
  logic [31:0] adr = 32'h0;
  logic [31:0] datI = 32'h0;
  logic        we = 1'h0;
  logic        cyc = 1'h0;
  logic        stb = 1'h0;
  logic [31:0] datO;
  logic [31:0] rd;
  logic [31:0] b;
  logic        ack;
  wire  [1:0]  ev, eLo, eHi, pin, pinOe, irq;
  int          numErrors = 0;
  int          nTests = 0;
  int          n;
  int          dv[10] = '{3, 6, 24, 4, 8, 16, 64, 256, 1024, 4096};
  logic [31:0] dc[4] = '{32'h0, 32'h3, 32'h2, 32'h1};
  always #12.5 mclk = ~mclk;
  dual_timer_pins pins_u (.mclk(mclk), .eventInput(ev), .edgeLower(eLo), .edgeUpper(eHi));
  dual_timer_counter dut_u (.mclk(mclk), .rst(rst), .wb_adr_i(adr), .wb_dat_i(datI), .wb_dat_o(datO),
    .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .eventInput(ev),
    .edgeLower(eLo), .edgeUpper(eHi), .comparePin(pin), .comparePinOe(pinOe), .matchIrq(irq));
  task stopTest;
    $display("checks %0d errors %0d", nTests, numErrors);
    if (numErrors == 0 && nTests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task wr(input logic [31:0] a, input logic [7:0] d, input logic w = 1'h1);
    int k;
    @(posedge mclk);
    adr <= a;
    datI <= {24'h0, d};
    we <= w;
    cyc <= 1'h1;
    stb <= 1'h1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (ack !== 1'h1 && k < 20);
    rd = datO;
    cyc <= 1'h0;
    stb <= 1'h0;
    if (k == 20) begin
      numErrors++;
      stopTest();
    end
  endtask
  task rdChk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    wr(a, 8'h00, 1'h0);
    `CHK(rd & m, e)
  endtask
  task doReset;
    @(posedge mclk);
    rst <= 1'h1;
    repeat (5) @(posedge mclk);
    rst <= 1'h0;
  endtask
  // counts started at reset must wrap onto a zero match before chaining
  task prep(input logic [7:0] lm);
    wr(32'h08, 8'h00);
    wr(32'h0C, 8'h00);
    repeat (600) @(posedge mclk);
    wr(32'h08, lm);
  endtask
  task half(output int c);
    logic v;
    v = pin[0];
    c = 0;
    do begin
      @(posedge mclk);
      c++;
    end while (pin[0] === v && c < 5000);
    if (c >= 5000) begin
      numErrors++;
      stopTest();
    end
  endtask
  initial begin
    doReset();
    rdChk(32'h1C, 32'hFF, 32'h0);
    rdChk(32'h40, 32'hFF, 32'h0);
    $display("test reset done");
    for (int p = 0; p < 2; p++) begin
      doReset();
      b = 32'h20 * p;
      wr(b, 8'h07);
      wr(b + 32'h08, 8'h05);
      pins_u.pulse(p, 3);
      rdChk(b + 32'h08, 32'hFF, 32'h3);
      pins_u.pulse(p, 3);
      rdChk(b + 32'h08, 32'hFF, 32'h0);
      rdChk(b + 32'h14, 32'h1, 32'h1);
      wr(b + 32'h14, 8'h01);
      rdChk(b + 32'h14, 32'h1, 32'h0);
    end
    $display("test event count done");
    for (int e = 1; e < 4; e++) begin
      doReset();
      wr(32'h00, 8'h0F);
      wr(32'h10, e[7:0]);
      pins_u.pulse(0, 2);
      pins_u.setEdge(0, 1'h1);
      pins_u.pulse(0, 1);
      pins_u.setEdge(0, 1'h0);
      rdChk(32'h08, 32'hFF, dc[e]);
      pins_u.pulse(0, 2);
      rdChk(32'h08, 32'hFF, dc[e]);
      rdChk(32'h14, 32'h4, 32'h4);
    end
    // upper capture: rises eight edges apart, count restarts at the first
    doReset();
    wr(32'h04, 8'h08);
    wr(32'h10, 8'h08);
    pins_u.setUpper(0, 1'h1);
    pins_u.setUpper(0, 1'h0);
    pins_u.setUpper(0, 1'h1);
    rdChk(32'h0C, 32'hFF, 32'h7);
    rdChk(32'h14, 32'h8, 32'h8);
    $display("test capture done");
    doReset();
    prep(8'h00);
    wr(32'h00, 8'h07);
    wr(32'h04, 8'h23);
    wr(32'h08, 8'h01);
    wr(32'h0C, 8'h01);
    wr(32'h14, 8'h0F);
    #1;
    `CHK(irq[0], 1'h0)
    pins_u.pulse(0, 257);
    rdChk(32'h08, 32'hFF, 32'h1);
    rdChk(32'h0C, 32'hFF, 32'h1);
    pins_u.pulse(0, 1);
    rdChk(32'h08, 32'hFF, 32'h0);
    rdChk(32'h14, 32'h3, 32'h1);
    `CHK(irq[0], 1'h1)
    $display("test chained count done");
    for (int i = 0; i < 10; i++) begin
      doReset();
      prep(8'h01);
      wr(32'h18, 8'h01);
      wr(32'h00, i < 3 ? 8'h00 : 8'(i - 3));
      wr(32'h04, i < 3 ? 8'(i) : 8'h23);
      wr(32'h0C, i < 3 ? 8'h02 : 8'h00);
      half(n);
      half(n);
      `CHK(n, dv[i])
    end
    #1;
    `CHK(pinOe[0], 1'h1)
    wr(32'h04, 8'h10);
    #1;
    `CHK(pinOe[0], 1'h0)
    $display("test compare done");
    stopTest();
  end
endmodule
